// ### logic/plp_palette_port.sv
// plp_palette_port: host byte i/o access to a 256 x 18 colour table,
// pixel mask, read/write index sequencing and pixel lookup path
// assumes single-cycle host strobes on clk, general input on async pins
//
// Notes on behaviour
// - mask ANDs pixel index before lookup
// - read index write sets pointer, arms read
// - read sequence returns red, green, blue
// - read bytes carry six bits, top zero
// - addressed entry loaded into data register
// - after three reads pointer increments, reloads
// - status bits 1-0: 00 write, 11 read
// - index/status reads never disturb sequences
// - write index write sets pointer, arms write
// - two writes build 12-bit holding value (red, green)
// - third write stores holding value to table
// - write pointer increments after each entry
// - gip enable makes write index read return inputs
// - general input data routed onto host data
// - read index and status share one address
`timescale 1ns/1ps
`default_nettype none
module plp_palette_port
    import plp_pkg::*;
#(
    parameter int DEPTH = 256                // table entries
) (
    input  wire logic        clk,            // register and pixel clock
    input  wire logic        rst_n,          // async reset, active low
    input  wire logic [15:0] io_addr,        // host i/o address
    input  wire logic        io_wr,          // write strobe, one cycle
    input  wire logic        io_rd,          // read strobe, one cycle
    input  wire logic [7:0]  io_wdata,       // write data
    output var  logic [7:0]  io_rdata,       // read data, next cycle
    output var  logic        io_rvalid,      // read data valid pulse
    input  wire logic [7:0]  extended_lut_control_reg, // gip enable in bit 2
    input  wire logic [7:0]  general_input_lines,      // external input pins
    input  wire logic [7:0]  pixel_index_bus,          // pixel index
    output var  logic [17:0] pixel_colour    // looked-up r,g,b
);
    // elaboration check: the pointers are 8 bits, so the table is 256
    if (DEPTH != 256) begin : g_depth_chk
        $error("plp_palette_port: DEPTH must be 256");
    end

    logic [PLP_ENTRY_W-1:0] lut_mem [DEPTH];    // colour table
    logic [7:0]  pixel_mask_reg;                // pixel mask
    logic [7:0]  rd_ptr_reg;                    // read pointer
    logic [7:0]  wr_ptr_reg;                    // write pointer
    logic [1:0]  cycle_status_reg;              // last_cycle_field
    plp_comp_e   comp_reg;                      // component counter
    logic        rd_load_reg;                   // reload data reg pending
    logic [PLP_ENTRY_W-1:0] data_reg;           // read data register
    logic [11:0] hold_reg;                      // red,green held
    logic [7:0]  gip_sync;                      // synchronised inputs

    logic        sel_mask;                      // mask address hit
    logic        sel_ridx;                      // read index / status hit
    logic        sel_widx;                      // write index hit
    logic        sel_data;                      // data port hit
    logic        data_rd;                       // data port read strobe
    logic        data_wr;                       // data port write strobe
    logic [PLP_COMP_W-1:0] wr_comp;              // incoming component

    assign sel_mask = (io_addr == PLP_ADDR_MASK);
    assign sel_ridx = (io_addr == PLP_ADDR_RIDX_STAT);
    assign sel_widx = (io_addr == PLP_ADDR_WIDX);
    assign sel_data = (io_addr == PLP_ADDR_DATA);
    assign data_rd  = io_rd && sel_data;
    assign data_wr  = io_wr && sel_data;
    assign wr_comp  = io_wdata[PLP_COMP_W-1:0];

    // general input pins cross into clk domain
    plp_sync3 #(.W(8)) i_plp_sync3 (
        .clk      (clk),
        .rst_n    (rst_n),
        .pin_in   (general_input_lines),
        .sync_out (gip_sync)
    );

    // pixel mask register, host access any time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pixel_mask_reg <= PLP_MASK_RST;
        end else if (io_wr && sel_mask) begin
            pixel_mask_reg <= io_wdata;
        end
    end

    // pixel lookup every clock, masked index
    always_ff @(posedge clk) begin
        pixel_colour <= lut_mem[pixel_index_bus & pixel_mask_reg];
    end

    // component counter: index writes restart at red, data accesses step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            comp_reg <= PLP_RED;
        end else if (io_wr && (sel_ridx || sel_widx)) begin
            comp_reg <= PLP_RED;
        end else if (data_rd || data_wr) begin
            unique case (comp_reg)
                PLP_RED:   comp_reg <= PLP_GREEN;
                PLP_GREEN: comp_reg <= PLP_BLUE;
                PLP_BLUE:  comp_reg <= PLP_RED;
                default:   comp_reg <= PLP_RED;  // illegal code
            endcase
        end
    end

    // read pointer: set by index write, step after blue read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr_reg <= 8'h00;
        end else if (io_wr && sel_ridx) begin
            rd_ptr_reg <= io_wdata;
        end else if (data_rd && comp_reg == PLP_BLUE) begin
            rd_ptr_reg <= rd_ptr_reg + 8'h01;
        end
    end

    // reload request: after index write or after a finished entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_load_reg <= 1'b0;
        end else begin
            rd_load_reg <= (io_wr && sel_ridx) ||
                           (data_rd && comp_reg == PLP_BLUE);
        end
    end

    // data register loads addressed entry one cycle after request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_reg <= '0;
        end else if (rd_load_reg) begin
            data_reg <= lut_mem[rd_ptr_reg];
        end
    end

    // write sequence: hold red and green, store on blue
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= '0;
        end else if (data_wr && comp_reg == PLP_RED) begin
            hold_reg[11:6] <= wr_comp;
        end else if (data_wr && comp_reg == PLP_GREEN) begin
            hold_reg[5:0] <= wr_comp;
        end
    end

    // table store on third byte
    always_ff @(posedge clk) begin
        if (data_wr && comp_reg == PLP_BLUE) begin
            lut_mem[wr_ptr_reg] <= {hold_reg, wr_comp};
        end
    end

    // write pointer: set by index write, step after each entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= 8'h00;
        end else if (io_wr && sel_widx) begin
            wr_ptr_reg <= io_wdata;
        end else if (data_wr && comp_reg == PLP_BLUE) begin
            wr_ptr_reg <= wr_ptr_reg + 8'h01;
        end
    end

    // status: which index was written last
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_status_reg <= PLP_STS_WRITE;
        end else if (io_wr && sel_ridx) begin
            cycle_status_reg <= PLP_STS_READ;
        end else if (io_wr && sel_widx) begin
            cycle_status_reg <= PLP_STS_WRITE;
        end
    end

    // read mux; index and status reads touch no sequence state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata  <= 8'h00;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= io_rd;
            if (!io_rd) begin
                io_rdata <= 8'h00;
            end else if (sel_mask) begin
                io_rdata <= pixel_mask_reg;
            end else if (sel_ridx) begin
                io_rdata <= {6'h00, cycle_status_reg};
            end else if (sel_widx) begin
                if (extended_lut_control_reg[PLP_GIP_EN_BIT]) begin
                    io_rdata <= gip_sync;
                end else begin
                    io_rdata <= wr_ptr_reg;
                end
            end else if (sel_data) begin
                unique case (comp_reg)
                    PLP_RED:   io_rdata <= {2'h0, data_reg[17:12]};
                    PLP_GREEN: io_rdata <= {2'h0, data_reg[11:6]};
                    PLP_BLUE:  io_rdata <= {2'h0, data_reg[5:0]};
                    default:   io_rdata <= 8'h00;
                endcase
            end else begin
                io_rdata <= 8'h00; // unmapped
            end
        end
    end

    // checks

    // a read-index write arms a read: status shows the read code
    status_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_wr && sel_ridx |=> cycle_status_reg == PLP_STS_READ)
        else $error("status not read after read index write");
    // a write-index write arms a write: status shows the write code
    status_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_wr && sel_widx |=> cycle_status_reg == PLP_STS_WRITE)
        else $error("status not write after write index write");
    // status byte reads zero above its two-bit field
    status_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_rd && sel_ridx |=> io_rdata[7:2] == 6'h00)
        else $error("status upper bits set");

    // a read-index write loads the pointer and asks for a reload
    ridx_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_wr && sel_ridx |=> rd_ptr_reg == $past(io_wdata) && rd_load_reg)
        else $error("read index not loaded");
    // a write-index write loads the write pointer
    widx_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_wr && sel_widx |=> wr_ptr_reg == $past(io_wdata))
        else $error("write index not loaded");
    // mask writes take effect at the next edge
    mask_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_wr && sel_mask |=> pixel_mask_reg == $past(io_wdata))
        else $error("pixel mask not loaded");

    // the read pointer steps after the blue byte of a read
    rptr_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        data_rd && comp_reg == PLP_BLUE && !io_wr
        |=> rd_ptr_reg == $past(rd_ptr_reg) + 8'h01)
        else $error("read pointer did not step");
    // the write pointer steps after the blue byte of a write
    wptr_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        data_wr && comp_reg == PLP_BLUE
        |=> wr_ptr_reg == $past(wr_ptr_reg) + 8'h01)
        else $error("write pointer did not step");
    // the third write lands the assembled entry in the table
    entry_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        data_wr && comp_reg == PLP_BLUE
        |=> lut_mem[$past(wr_ptr_reg)] == $past({hold_reg, wr_comp}))
        else $error("entry not stored");
    // the red byte of a write lands at the top of the holding value
    hold_red_a: assert property (@(posedge clk) disable iff (!rst_n)
        data_wr && comp_reg == PLP_RED |=> hold_reg[11:6] == $past(wr_comp))
        else $error("red component not held");

    // index writes restart the component count at red
    comp_red_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_wr && (sel_ridx || sel_widx) |=> comp_reg == PLP_RED)
        else $error("counter not restarted");
    // the component counter keeps to its three one-hot codes
    comp_hot_a: assert property (@(posedge clk) disable iff (!rst_n)
        comp_reg inside {PLP_RED, PLP_GREEN, PLP_BLUE})
        else $error("component counter code illegal");

    // data bytes carry zeros in their top two bits
    rdata_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        data_rd |=> io_rvalid && io_rdata[7:6] == 2'h0)
        else $error("data byte upper bits set");
    // the red byte returns the top field of the data register
    red_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
        data_rd && comp_reg == PLP_RED
        |=> io_rdata == {2'h0, $past(data_reg[17:12])})
        else $error("red byte not returned first");
    // a read-index write reloads the data register with the new entry
    reload_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_wr && sel_ridx ##1 !io_wr
        |=> data_reg == $past(lut_mem[rd_ptr_reg]))
        else $error("data register not loaded");

    // non-data reads leave the component counter alone
    stat_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_rd && !io_wr |=> $stable(comp_reg) || $past(sel_data))
        else $error("read disturbed sequence");
    // non-data reads leave both pointers alone
    ptr_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_rd && !io_wr && !sel_data
        |=> $stable(rd_ptr_reg) && $stable(wr_ptr_reg))
        else $error("read disturbed a pointer");
    // with the enable set the write-index read returns the inputs
    gip_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_rd && sel_widx && extended_lut_control_reg[PLP_GIP_EN_BIT]
        |=> io_rdata == $past(gip_sync))
        else $error("gip data not returned");

    // main scenarios
    wr_seq_c: cover property (@(posedge clk) disable iff (!rst_n)
        data_wr && comp_reg == PLP_BLUE);
    rd_seq_c: cover property (@(posedge clk) disable iff (!rst_n)
        data_rd && comp_reg == PLP_BLUE);
    gip_c: cover property (@(posedge clk) disable iff (!rst_n)
        io_rd && sel_widx && extended_lut_control_reg[PLP_GIP_EN_BIT]);
    restart_c: cover property (@(posedge clk) disable iff (!rst_n)
        io_wr && sel_widx && comp_reg != PLP_RED);
    mask_c: cover property (@(posedge clk) disable iff (!rst_n)
        io_wr && sel_mask && io_wdata != 8'hff);
endmodule : plp_palette_port
`default_nettype wire

// ### logic/plp_pkg.sv
// palette lookup port package: i/o addresses, fields, status codes
// assumes a byte-wide host i/o port with 16-bit addresses
package plp_pkg;
    localparam logic [15:0] PLP_ADDR_MASK      = 16'h03c6; // pixel mask
    localparam logic [15:0] PLP_ADDR_RIDX_STAT = 16'h03c7; // rd index / status
    localparam logic [15:0] PLP_ADDR_WIDX      = 16'h03c8; // write index / gip
    localparam logic [15:0] PLP_ADDR_DATA      = 16'h03c9; // data port
    localparam int          PLP_COMP_W         = 6;        // bits per colour
    localparam int          PLP_ENTRY_W        = 18;       // bits per entry
    localparam int          PLP_GIP_EN_BIT     = 2;        // gip read enable bit
    localparam logic [1:0]  PLP_STS_WRITE      = 2'h0;     // last was write
    localparam logic [1:0]  PLP_STS_READ       = 2'h3;     // last was read
    localparam logic [7:0]  PLP_MASK_RST       = 8'hff;    // mask after reset
    // component counter, one-hot
    typedef enum logic [2:0] {
        PLP_RED   = 3'b001,
        PLP_GREEN = 3'b010,
        PLP_BLUE  = 3'b100
    } plp_comp_e;
endpackage : plp_pkg

// ### logic/plp_sync3.sv
// plp_sync3: three-flop synchroniser for a bus of pin inputs
// assumes the pins are asynchronous to clk; a change is accepted once
// the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module plp_sync3 #(
    parameter int W = 8                 // bus width
) (
    input  wire logic         clk,      // register clock
    input  wire logic         rst_n,    // async reset, active low
    input  wire logic [W-1:0] pin_in,   // raw pins
    output var  logic [W-1:0] sync_out  // filtered value
);
    logic [W-1:0] s1_reg;               // metastability stage
    logic [W-1:0] s2_reg;               // second stage
    logic [W-1:0] s3_reg;               // third stage

    // shift chain; only s2 reads s1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // accept a new value per bit once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_out <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    sync_out[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : plp_sync3
`default_nettype wire

// ### bench/palette_lookup_port_tb.sv
// palette_lookup_port_tb: self-checking bench for the palette port
// assumes plp_pkg and the design modules under logic/ compile first
`timescale 1ns/1ps
`default_nettype none
module palette_lookup_port_tb;
    import plp_pkg::*;
    logic        clk;       // 250 MHz clock
    logic        rst_n;     // async reset, active low
    logic [15:0] io_addr;   // host address
    logic        io_wr;     // write strobe
    logic        io_rd;     // read strobe
    logic [7:0]  io_wdata;  // write data
    logic [7:0]  io_rdata;  // read data
    logic        io_rvalid; // read valid pulse
    logic [7:0]  ext_ctl;   // gip enable in bit 2
    logic [7:0]  gin;       // general input pins
    logic [7:0]  pix;       // pixel index
    logic [17:0] colour;    // looked-up colour
    int          n_errors;  // mismatches
    int          compares;  // comparisons made
    int          cyc = 0;   // cycles run, for the timeout
    localparam int CYC_LIMIT = 5000; // ceiling; the tests need far fewer

    plp_palette_port #(.DEPTH(256)) i_plp_palette_port (
        .clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .extended_lut_control_reg(ext_ctl),
        .general_input_lines(gin), .pixel_index_bus(pix),
        .pixel_colour(colour));

    // clock source, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // print counts and verdict, then stop
    task automatic end_sim;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // cycle counter for the hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // compare one value and count it
    task automatic chk(input string what, input logic [17:0] exp,
                       input logic [17:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    // one write strobe; a gap cycle follows before the next strobe
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr    <= 1'b0;
    endtask : wr

    // one read strobe; answer judged the cycle after it is taken
    task automatic rdx(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd   <= 1'b0;
        #1;
        chk("rvalid", 18'h1, {17'h0, io_rvalid});
        chk("rdata", {10'h0, exp}, {10'h0, io_rdata});
        // answer stands one cycle only, then returns to idle
        @(posedge clk);
        #1;
        chk("rvalid_idle", 18'h0, {17'h0, io_rvalid});
        chk("rdata_idle", 18'h0, {10'h0, io_rdata});
    endtask : rdx

    // one whole entry, red first; t_write passes bytes with top bits set to prove they drop
    task automatic wrent(input logic [7:0] r, g, b);
        wr(PLP_ADDR_DATA, r);
        wr(PLP_ADDR_DATA, g);
        wr(PLP_ADDR_DATA, b);
    endtask : wrent

    // wait for the lookup pipe, then judge the pixel output
    task automatic pixchk(input logic [17:0] exp);
        repeat (3) @(posedge clk);
        #1;
        chk("pixel_colour", exp, colour);
    endtask : pixchk

    // values right after reset
    task automatic t_reset;
        rdx(PLP_ADDR_MASK, PLP_MASK_RST);
        rdx(PLP_ADDR_RIDX_STAT, {6'h00, PLP_STS_WRITE});
        rdx(PLP_ADDR_WIDX, 8'h00);
    endtask : t_reset

    // two entries across the pointer wrap, pointer readback
    task automatic t_write;
        wr(PLP_ADDR_WIDX, 8'hff);
        rdx(PLP_ADDR_RIDX_STAT, 8'h00);
        wrent(8'hc1, 8'h82, 8'h43);
        wrent(8'hff, 8'h40, 8'h2a);
        rdx(PLP_ADDR_WIDX, 8'h01);
    endtask : t_write

    // read both entries back, status peeked mid-sequence
    task automatic t_read;
        wr(PLP_ADDR_RIDX_STAT, 8'hff);
        rdx(PLP_ADDR_RIDX_STAT, 8'h03);
        rdx(PLP_ADDR_DATA, 8'h01);
        rdx(PLP_ADDR_DATA, 8'h02);
        rdx(PLP_ADDR_RIDX_STAT, 8'h03);
        rdx(PLP_ADDR_DATA, 8'h03);
        rdx(PLP_ADDR_DATA, 8'h3f);
        rdx(PLP_ADDR_DATA, 8'h00);
        rdx(PLP_ADDR_DATA, 8'h2a);
    endtask : t_read

    // index rewrite after a lone red byte restarts at red
    task automatic t_restart;
        wr(PLP_ADDR_WIDX, 8'h05);
        wr(PLP_ADDR_DATA, 8'h11);
        wr(PLP_ADDR_WIDX, 8'h05);
        wrent(8'h07, 8'h08, 8'h09);
        wr(PLP_ADDR_RIDX_STAT, 8'h05);
        rdx(PLP_ADDR_DATA, 8'h07);
        rdx(PLP_ADDR_DATA, 8'h08);
        rdx(PLP_ADDR_DATA, 8'h09);
        rdx(PLP_ADDR_WIDX, 8'h06);
    endtask : t_restart

    // mask picks the lookup entry for the pixel path
    task automatic t_pixel;
        wr(PLP_ADDR_MASK, 8'h00);
        @(posedge clk);
        pix <= 8'hff;
        pixchk({6'h3f, 6'h00, 6'h2a});
        wr(PLP_ADDR_MASK, 8'hff);
        pixchk({6'h01, 6'h02, 6'h03});
        rdx(PLP_ADDR_MASK, 8'hff);
    endtask : t_pixel

    // general input read on the write-index address
    task automatic t_gip;
        @(posedge clk);
        ext_ctl <= 8'h04;
        gin     <= 8'ha5;
        repeat (8) @(posedge clk);
        rdx(PLP_ADDR_WIDX, 8'ha5);
        @(posedge clk);
        ext_ctl <= 8'h00;
        rdx(PLP_ADDR_WIDX, 8'h06);
    endtask : t_gip

    // unmapped address: write ignored, read gives zero
    task automatic t_unmapped;
        wr(16'h03c5, 8'h00);
        rdx(16'h03c5, 8'h00);
        rdx(PLP_ADDR_MASK, 8'hff);
    endtask : t_unmapped

    // main sequence
    initial begin
        n_errors = 0;
        compares = 0;
        rst_n    = 1'b0;
        io_addr  = 16'h0000;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
        ext_ctl  = 8'h00;
        gin      = 8'h00;
        pix      = 8'h00;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        fork
            begin
                t_reset();
                t_write();
                t_read();
                t_restart();
                t_pixel();
                t_gip();
                t_unmapped();
            end
            // hang guard: a stuck run counts as a mismatch
            begin
                wait (cyc >= CYC_LIMIT);
                n_errors++;
                $display("[ERR] timeout exp %0d got %0d", CYC_LIMIT, cyc);
            end
        join_any
        disable fork;
        end_sim();
    end
endmodule : palette_lookup_port_tb
`default_nettype wire
